// [logic/hcl_loader.sv]
// Power-up configuration loader: reads the EEPROM image once and holds
// the descriptor settings. Assumes addrTwoByte is a stable strap level.
`timescale 1ns/100ps
module hcl_loader
  import hcl_pkg::*;
#(
  parameter logic [7:0] SPI_HALF = SPI_HALF_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic addrTwoByte,
  input wire logic spiMiso,
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi,
  output logic [15:0] vendorId,
  output logic [15:0] productId,
  output logic [7:0] deviceReleaseIdHi,
  output logic [3:0] enabledPortOcFilterTime,
  output logic [3:0] disabledPortOcFilterTime,
  output logic [3:0] usablePortMap,
  output logic [3:0] removablePortMap,
  output logic [2:0] numPorts,
  output logic [7:0] deviceRemovable,
  output logic [7:0] portPwrCtrlMask,
  output logic [7:0] maxPowerFs,
  output logic [7:0] maxPowerHs,
  output logic [7:0] controllerCurrentFs,
  output logic [7:0] controllerCurrentHs,
  output logic [7:0] portPowerGoodDelay,
  output logic acceptZeroDescriptorType,
  output logic partOfCompositeFlag,
  output logic restrictToFullSpeed,
  output logic suppressStatusLeds,
  output logic sharedPortPowerSwitch,
  output logic [7:0] hubCharLo,
  output logic vendorClassMode,
  output logic configDone
);

  typedef enum logic [1:0] {ST_BOOT, ST_HEAD, ST_BODY, ST_DONE} hcl_st_e;
  typedef struct packed {
    hcl_st_e st;
    logic rdStart;
    logic [8:0] rdAddr;
    logic [7:0] rdCount;
    logic [3:0] idx;
    logic [7:0] fmt;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [7:0] didHi;
    logic [3:0] ocEn;
    logic [3:0] ocDis;
    logic [3:0] usable;
    logic [3:0] remov;
    logic [2:0] nPorts;
    logic [7:0] devRem;
    logic [7:0] mpFs;
    logic [7:0] mpHs;
    logic [7:0] ccFs;
    logic [7:0] ccHs;
    logic [7:0] pGood;
    logic accept0;
    logic comp;
    logic fsOnly;
    logic noLeds;
    logic gang;
    logic [7:0] hubChar;
    logic vendorClass;
    logic done;
  } hcl_ld_s;

  localparam hcl_ld_s LD_RST = '{st: ST_BOOT, vid: DEF_VID, pid: DEF_PID, didHi: DEF_DID_HI,
    ocEn: DEF_OC_TIME, ocDis: DEF_OC_TIME, usable: DEF_USABLE, remov: DEF_USABLE,
    nPorts: DEF_NUM_PORTS, devRem: DEF_REMOVABLE, mpFs: DEF_MAXPWR_FS, mpHs: DEF_MAXPWR_HS,
    ccFs: DEF_CTRL_FS, ccHs: DEF_CTRL_HS, pGood: DEF_PGOOD, accept0: 1'b1,
    hubChar: DEF_HUB_CHAR, default: '0};

  hcl_ld_s s_r;
  hcl_ld_s s_nxt;
  logic rdVal;
  logic rdDone;
  logic [7:0] rdData;

  // Count of set bits in a port nibble
  function automatic logic [2:0] pop4(input logic [3:0] v);
    pop4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
  endfunction : pop4

  // Mask covering the lowest n logical ports; n of four or more gives all ones
  function automatic logic [3:0] low_mask(input logic [2:0] n);
    logic [4:0] ones;
    ones = (5'h01 << n) - 5'h01;
    low_mask = ones[3:0];
    if (n > 3'h3) begin
      low_mask = 4'hf;
    end
  endfunction : low_mask

  // ---------------------------------------------------------------
  // EEPROM reader
  // ---------------------------------------------------------------
  hcl_spi_rd #(.HALF(SPI_HALF)) u_rd (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(s_r.rdStart),
    .twoByte(addrTwoByte),
    .addr(s_r.rdAddr),
    .count(s_r.rdCount),
    .miso(spiMiso),
    .sclk(spiSclk),
    .csN(spiCsN),
    .mosi(spiMosi),
    .byteVal(rdVal),
    .byteData(rdData),
    .done(rdDone)
  );

  // ---------------------------------------------------------------
  // Load sequence and field decode
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdStart = 1'b0;
    case (s_r.st)
      ST_BOOT: begin
        s_nxt.rdStart = 1'b1;
        s_nxt.rdAddr = ADDR_HEAD;
        s_nxt.rdCount = LEN_HEAD;
        s_nxt.st = ST_HEAD;
      end
      ST_HEAD: begin
        if (rdVal) begin
          s_nxt.fmt = rdData;
        end
        if (rdDone) begin
          if (s_r.fmt == FMT_SHORT || s_r.fmt == FMT_EXT) begin
            s_nxt.rdStart = 1'b1;
            s_nxt.rdAddr = ADDR_BODY;
            s_nxt.rdCount = (s_r.fmt == FMT_EXT) ? LEN_EXT : LEN_SHORT;
            s_nxt.idx = IDX_VID_LO;
            s_nxt.st = ST_BODY;
          end else begin
            // blank or unknown image gives vendor class
            s_nxt.vendorClass = 1'b1;
            s_nxt.done = 1'b1;
            s_nxt.st = ST_DONE;
          end
        end
      end
      ST_BODY: begin
        if (rdVal) begin
          s_nxt.idx = s_r.idx + 4'h1;
          case (s_r.idx)
            IDX_VID_LO: s_nxt.vid[7:0] = rdData;
            IDX_VID_HI: s_nxt.vid[15:8] = rdData;
            IDX_PID_LO: s_nxt.pid[7:0] = rdData;
            IDX_PID_HI: s_nxt.pid[15:8] = rdData;
            IDX_DID_HI: s_nxt.didHi = rdData;
            IDX_OC: begin
              s_nxt.ocEn = rdData[7:4];
              s_nxt.ocDis = rdData[3:0];
            end
            // port count and logical removable map
            IDX_PORTS: begin
              s_nxt.usable = rdData[7:4];
              s_nxt.remov = rdData[3:0];
              s_nxt.nPorts = pop4(rdData[7:4]);
              s_nxt.devRem = {3'b000, ~rdData[3:0] & low_mask(pop4(rdData[7:4])), 1'b0};
            end
            IDX_MAXPWR: begin
              s_nxt.mpFs = rdData;
              s_nxt.mpHs = rdData;
            end
            IDX_CTRLCUR: begin
              s_nxt.ccFs = rdData;
              s_nxt.ccHs = rdData;
            end
            IDX_PGOOD: s_nxt.pGood = rdData;
            IDX_OPT: begin
              s_nxt.accept0 = rdData[OPT_ACCEPT0];
              s_nxt.comp = rdData[OPT_COMPOSITE];
              s_nxt.fsOnly = rdData[OPT_FS_ONLY];
              s_nxt.noLeds = rdData[OPT_NO_LEDS];
              s_nxt.gang = rdData[OPT_GANG];
            end
            default: ;
          endcase
        end
        if (rdDone) begin
          s_nxt.done = 1'b1;
          s_nxt.st = ST_DONE;
        end
      end
      // held until the next reset
      default: ;
    endcase
    s_nxt.hubChar = hub_char(s_nxt.gang, s_nxt.comp, s_nxt.noLeds);
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= LD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register, except the port power control mask, which is the constant PWR_CTRL_MASK
  assign vendorId = s_r.vid;
  assign productId = s_r.pid;
  assign deviceReleaseIdHi = s_r.didHi;
  assign enabledPortOcFilterTime = s_r.ocEn;
  assign disabledPortOcFilterTime = s_r.ocDis;
  assign usablePortMap = s_r.usable;
  assign removablePortMap = s_r.remov;
  assign numPorts = s_r.nPorts;
  assign deviceRemovable = s_r.devRem;
  assign portPwrCtrlMask = PWR_CTRL_MASK;
  assign maxPowerFs = s_r.mpFs;
  assign maxPowerHs = s_r.mpHs;
  assign controllerCurrentFs = s_r.ccFs;
  assign controllerCurrentHs = s_r.ccHs;
  assign portPowerGoodDelay = s_r.pGood;
  assign acceptZeroDescriptorType = s_r.accept0;
  assign partOfCompositeFlag = s_r.comp;
  assign restrictToFullSpeed = s_r.fsOnly;
  assign suppressStatusLeds = s_r.noLeds;
  assign sharedPortPowerSwitch = s_r.gang;
  assign hubCharLo = s_r.hubChar;
  assign vendorClassMode = s_r.vendorClass;
  assign configDone = s_r.done;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_mask_all_ones: assert property (portPwrCtrlMask == PWR_CTRL_MASK)
    else $error("port power control mask not all ones");
  a_removable_lsb: assert property (deviceRemovable[0] == 1'b0 &&
    (deviceRemovable[4:1] & ~low_mask(numPorts)) == 4'h0)
    else $error("removable bitmap has bits beyond the ports");
  a_blank_vendor: assert property (s_r.st == ST_HEAD && rdDone &&
    s_r.fmt == FMT_BLANK |=> vendorClassMode && configDone)
    else $error("blank image did not give vendor class");
  a_body_length: assert property (s_r.st == ST_HEAD && rdDone &&
    s_r.fmt == FMT_EXT |=> s_r.rdStart && s_r.rdCount == LEN_EXT && s_r.rdAddr == ADDR_BODY)
    else $error("extended image body length wrong");
  a_load_once: assert property (configDone |=> configDone && $stable(vendorId) &&
    $stable(hubCharLo) && $stable(numPorts) && !s_r.rdStart)
    else $error("settings changed after load");
  a_vid_high: assert property (s_r.st == ST_BODY && rdVal &&
    s_r.idx == IDX_VID_HI |=> vendorId[15:8] == $past(rdData))
    else $error("vendor id high byte not taken");
  a_oc_split: assert property (s_r.st == ST_BODY && rdVal && s_r.idx == IDX_OC |=>
    {enabledPortOcFilterTime, disabledPortOcFilterTime} == $past(rdData))
    else $error("filter time nibbles wrong");
  a_port_count: assert property (s_r.st == ST_BODY && rdVal &&
    s_r.idx == IDX_PORTS |=> numPorts == pop4($past(rdData[7:4])))
    else $error("port count not the usable bit count");
  a_power_both: assert property (s_r.st == ST_BODY && rdVal &&
    s_r.idx == IDX_MAXPWR |=> maxPowerFs == $past(rdData) && maxPowerHs == $past(rdData))
    else $error("max power not applied at both speeds");
  a_gang_char: assert property (hubCharLo[1:0] == {1'b0, ~sharedPortPowerSwitch} &&
    hubCharLo[4:3] == {1'b0, ~sharedPortPowerSwitch})
    else $error("hub characteristics disagree with ganging");
  a_head_first: assert property ($rose(configDone) |-> $past(s_r.st) != ST_BOOT)
    else $error("load finished without reading the format code");

  c_short_load: cover property (configDone && !vendorClassMode && s_r.fmt == FMT_SHORT);
  c_ext_load: cover property (configDone && s_r.fmt == FMT_EXT && sharedPortPowerSwitch);
  c_blank_load: cover property (configDone && vendorClassMode);

endmodule : hcl_loader

// [logic/hcl_pkg.sv]
// Constants shared by the configuration loader and its serial EEPROM reader.
// Assumes a serial EEPROM in SPI mode 0 answering the plain read instruction.

package hcl_pkg;

  // -----------------------------------------------------------------
  // Image formats and layout
  // -----------------------------------------------------------------
  localparam logic [7:0] FMT_SHORT = 8'hd0;
  localparam logic [7:0] FMT_EXT = 8'hd2;
  localparam logic [7:0] FMT_BLANK = 8'hff;
  localparam logic [7:0] LEN_HEAD = 8'h01;
  localparam logic [7:0] LEN_SHORT = 8'h06;
  localparam logic [7:0] LEN_EXT = 8'h0c;
  localparam logic [8:0] ADDR_HEAD = 9'h000;
  localparam logic [8:0] ADDR_BODY = 9'h001;
  localparam logic [3:0] IDX_VID_LO = 4'h1;
  localparam logic [3:0] IDX_VID_HI = 4'h2;
  localparam logic [3:0] IDX_PID_LO = 4'h3;
  localparam logic [3:0] IDX_PID_HI = 4'h4;
  localparam logic [3:0] IDX_DID_HI = 4'h6;
  localparam logic [3:0] IDX_OC = 4'h7;
  localparam logic [3:0] IDX_PORTS = 4'h8;
  localparam logic [3:0] IDX_MAXPWR = 4'h9;
  localparam logic [3:0] IDX_CTRLCUR = 4'ha;
  localparam logic [3:0] IDX_PGOOD = 4'hb;
  localparam logic [3:0] IDX_OPT = 4'hc;

  // Option byte bit positions
  localparam int OPT_ACCEPT0 = 7;
  localparam int OPT_COMPOSITE = 6;
  localparam int OPT_FS_ONLY = 5;
  localparam int OPT_NO_LEDS = 4;
  localparam int OPT_GANG = 2;

  // -----------------------------------------------------------------
  // Defaults after reset and for the short image
  // -----------------------------------------------------------------
  localparam logic [15:0] DEF_VID = 16'h1234; // Arbitrary value
  localparam logic [15:0] DEF_PID = 16'h5678; // Arbitrary value
  localparam logic [7:0] DEF_DID_HI = 8'h01; // Arbitrary value
  localparam logic [3:0] DEF_OC_TIME = 4'h8;
  localparam logic [3:0] DEF_USABLE = 4'hf;
  localparam logic [2:0] DEF_NUM_PORTS = 3'h4;
  localparam logic [7:0] DEF_REMOVABLE = 8'h00;
  localparam logic [7:0] PWR_CTRL_MASK = 8'hff;
  localparam logic [7:0] DEF_MAXPWR_FS = 8'h28;
  localparam logic [7:0] DEF_MAXPWR_HS = 8'h57;
  localparam logic [7:0] DEF_CTRL_FS = 8'h50;
  localparam logic [7:0] DEF_CTRL_HS = 8'hae;
  localparam logic [7:0] DEF_PGOOD = 8'h32;
  localparam logic [7:0] DEF_HUB_CHAR = 8'h89;

  // -----------------------------------------------------------------
  // Serial EEPROM access
  // -----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam int CMD_A8_POS = 3;
  localparam logic [4:0] BITS_ADDR2 = 5'h18;
  localparam logic [4:0] BITS_ADDR1 = 5'h10;
  localparam logic [4:0] BITS_BYTE = 5'h08;
  localparam logic [7:0] SPI_HALF_DEF = 8'h04;

  // Low byte of the hub characteristics from the option bits
  function automatic logic [7:0] hub_char(input logic gang, input logic comp,
                                          input logic noLeds);
    hub_char = {~noLeds, 2'b00, 1'b0, ~gang, comp, 1'b0, ~gang};
  endfunction : hub_char

endpackage : hcl_pkg

// [logic/hcl_spi_rd.sv]
// Serial EEPROM sequential reader: one read instruction, then a run of bytes.
// Assumes an SPI mode 0 EEPROM; miso is synchronous to mclk.
`timescale 1ns/100ps
module hcl_spi_rd
  import hcl_pkg::*;
#(
  parameter logic [7:0] HALF = SPI_HALF_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic twoByte,
  input wire logic [8:0] addr,
  input wire logic [7:0] count,
  input wire logic miso,
  output logic sclk,
  output logic csN,
  output logic mosi,
  output logic byteVal,
  output logic [7:0] byteData,
  output logic done
);

  typedef enum logic [1:0] {SP_IDLE, SP_CMD, SP_DATA, SP_END} hcl_sp_e;
  typedef struct packed {
    hcl_sp_e ph;
    logic [7:0] div;
    logic sclk;
    logic csN;
    logic mosi;
    logic [23:0] tx;
    logic [4:0] bitCnt;
    logic [7:0] rx;
    logic [7:0] left;
    logic byteVal;
    logic [7:0] byteData;
    logic done;
  } hcl_sp_s;

  localparam hcl_sp_s SP_RST = '{ph: SP_IDLE, csN: 1'b1, default: '0};

  hcl_sp_s s_r;
  hcl_sp_s s_nxt;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic tick;
    logic [7:0] cmd;
    tick = 1'b0;
    cmd = CMD_READ;
    s_nxt = s_r;
    s_nxt.byteVal = 1'b0;
    s_nxt.done = 1'b0;
    if (s_r.ph != SP_IDLE) begin
      tick = (s_r.div == 8'h00);
      s_nxt.div = tick ? HALF - 8'h01 : s_r.div - 8'h01;
    end
    case (s_r.ph)
      SP_IDLE: begin
        if (start) begin
          s_nxt.csN = 1'b0;
          s_nxt.sclk = 1'b0;
          s_nxt.div = HALF - 8'h01;
          s_nxt.left = count;
          s_nxt.ph = SP_CMD;
          if (twoByte) begin
            s_nxt.tx = {cmd, 7'h00, addr};
            s_nxt.bitCnt = BITS_ADDR2;
          end else begin
            cmd[CMD_A8_POS] = addr[8];
            s_nxt.tx = {cmd, addr[7:0], 8'h00};
            s_nxt.bitCnt = BITS_ADDR1;
          end
          s_nxt.mosi = s_nxt.tx[23];
        end
      end
      SP_CMD: begin
        if (tick && !s_r.sclk) begin
          s_nxt.sclk = 1'b1;
          s_nxt.bitCnt = s_r.bitCnt - 5'h01;
        end else if (tick) begin
          s_nxt.sclk = 1'b0;
          if (s_r.bitCnt == 5'h00) begin
            s_nxt.ph = SP_DATA;
            s_nxt.bitCnt = BITS_BYTE;
          end else begin
            s_nxt.tx = {s_r.tx[22:0], 1'b0};
            s_nxt.mosi = s_r.tx[22];
          end
        end
      end
      SP_DATA: begin
        // Sample on the rising edge, turn around on the falling one
        if (tick && !s_r.sclk) begin
          s_nxt.sclk = 1'b1;
          s_nxt.rx = {s_r.rx[6:0], miso};
          s_nxt.bitCnt = s_r.bitCnt - 5'h01;
          if (s_r.bitCnt == 5'h01) begin
            s_nxt.byteVal = 1'b1;
            s_nxt.byteData = {s_r.rx[6:0], miso};
            s_nxt.left = s_r.left - 8'h01;
          end
        end else if (tick) begin
          s_nxt.sclk = 1'b0;
          if (s_r.bitCnt == 5'h00) begin
            if (s_r.left == 8'h00) begin
              s_nxt.ph = SP_END;
            end else begin
              s_nxt.bitCnt = BITS_BYTE;
            end
          end
        end
      end
      default: begin
        if (tick) begin
          s_nxt.csN = 1'b1;
          s_nxt.done = 1'b1;
          s_nxt.ph = SP_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= SP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sclk = s_r.sclk;
  assign csN = s_r.csN;
  assign mosi = s_r.mosi;
  assign byteVal = s_r.byteVal;
  assign byteData = s_r.byteData;
  assign done = s_r.done;

endmodule : hcl_spi_rd

// [tb/hcl_eeprom_model.sv]
// Behavioural serial EEPROM that answers the sequential read instruction.
// Assumes SPI mode 0 with a master that changes mosi after sclk falls.
`timescale 1ns/100ps
module hcl_eeprom_model (
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic twoByte,
  output logic miso,
  output logic [7:0] lastOp,
  output logic [8:0] lastAddr
);
  // -----------------------------------------------------------------
  // Storage and shift state
  // -----------------------------------------------------------------
  logic [7:0] mem [0:511];
  logic [23:0] hdr;
  logic [8:0] rdAddr;
  logic [7:0] shReg;
  int bitCnt;
  int dCnt;
  int hdrBits;

  // Blank part, line low before the first frame
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hff;
    miso = 1'b0;
    bitCnt = 0;
    dCnt = 0;
  end

  assign hdrBits = twoByte ? 24 : 16; // Instruction plus one or two address bytes

  // New frame restarts the bit counts
  always @(negedge csN) begin
    bitCnt = 0;
    dCnt = 0;
  end

  always @(posedge sclk) begin
    if (!csN) begin
      hdr = {hdr[22:0], mosi};
      bitCnt = bitCnt + 1;
      if (bitCnt == hdrBits) begin
        lastOp = twoByte ? hdr[23:16] : hdr[15:8];
        lastAddr = twoByte ? hdr[8:0] : {hdr[11], hdr[7:0]};
        rdAddr = lastAddr;
      end
    end
  end

  // image bytes served in address order, MSB first
  always @(negedge sclk) begin
    if (!csN && bitCnt >= hdrBits) begin
      if (dCnt % 8 == 0) begin
        shReg = mem[rdAddr];
        rdAddr = rdAddr + 9'h001;
      end
      miso <= shReg[7];
      shReg = {shReg[6:0], 1'b0};
      dCnt = dCnt + 1;
    end else begin
      miso <= ~miso; // Not driving: no stale bit to lean on
    end
  end

  // Released line shows the inverse of its last bit
  always @(posedge csN) miso <= ~miso;
endmodule : hcl_eeprom_model

// [tb/testbench.sv]
// Self-checking bench for the configuration loader and an EEPROM model.
// Assumes one 200 MHz clock; the serial clock phase is shortened to 2 cycles.
`timescale 1ns/100ps
module testbench;
  import hcl_pkg::*;
  // -----------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------
  logic mclk, rst_n, addrTwoByte, spiMiso, spiSclk, spiCsN, spiMosi;
  logic [15:0] vendorId, productId;
  logic [7:0] deviceReleaseIdHi, deviceRemovable, portPwrCtrlMask, maxPowerFs, maxPowerHs;
  logic [7:0] controllerCurrentFs, controllerCurrentHs, portPowerGoodDelay, hubCharLo;
  logic [3:0] enabledPortOcFilterTime, disabledPortOcFilterTime, usablePortMap;
  logic [3:0] removablePortMap;
  logic [2:0] numPorts;
  logic acceptZeroDescriptorType, partOfCompositeFlag, restrictToFullSpeed;
  logic suppressStatusLeds, sharedPortPowerSwitch, vendorClassMode, configDone;
  logic [7:0] lastOp;
  logic [8:0] lastAddr;
  logic [7:0] img [0:12];
  logic [7:0] pmTab [0:3] = '{8'h00, 8'hf0, 8'h9a, 8'h6f};
  logic [7:0] opTab [0:3] = '{8'h00, 8'hff, 8'h04, 8'h80};
  int fail_count = 0;
  int n_compared = 0;
  int seed = 32'h56ec7db4;

  hcl_loader #(.SPI_HALF(8'h02)) dut_u (.mclk, .rst_n, .addrTwoByte, .spiMiso, .spiSclk,
    .spiCsN, .spiMosi, .vendorId, .productId, .deviceReleaseIdHi, .enabledPortOcFilterTime,
    .disabledPortOcFilterTime, .usablePortMap, .removablePortMap, .numPorts, .deviceRemovable,
    .portPwrCtrlMask, .maxPowerFs, .maxPowerHs, .controllerCurrentFs, .controllerCurrentHs,
    .portPowerGoodDelay, .acceptZeroDescriptorType, .partOfCompositeFlag, .restrictToFullSpeed,
    .suppressStatusLeds, .sharedPortPowerSwitch, .hubCharLo, .vendorClassMode, .configDone);

  hcl_eeprom_model ee_u (.sclk(spiSclk), .csN(spiCsN), .mosi(spiMosi),
    .twoByte(addrTwoByte), .miso(spiMiso), .lastOp, .lastAddr);

  // Free-running core clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // -----------------------------------------------------------------
  // Checking helpers
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: %s is %h, expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Compared %0d values, %0d mismatches", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // Expected settings worked out from the image bytes
  task automatic check_all;
    logic ok, ext;
    logic [7:0] oc, pm, op, rem;
    int n;
    ok = img[0] == 8'hd0 || img[0] == 8'hd2;
    ext = img[0] == 8'hd2;
    oc = ext ? img[7] : 8'h88;
    pm = ext ? img[8] : 8'hff;
    op = ext ? img[12] : 8'h80;
    n = 0;
    rem = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (pm[4 + i]) begin
        n++;
        rem[n] = ~pm[n - 1];
      end
    end
    chk("vendor class", 16'(vendorClassMode), 16'(!ok));
    chk("vendor id", vendorId, ok ? {img[2], img[1]} : DEF_VID);
    chk("product id", productId, ok ? {img[4], img[3]} : DEF_PID);
    chk("release id", 16'(deviceReleaseIdHi), 16'(ok ? img[6] : DEF_DID_HI));
    chk("oc enabled", 16'(enabledPortOcFilterTime), 16'(oc[7:4]));
    chk("oc disabled", 16'(disabledPortOcFilterTime), 16'(oc[3:0]));
    chk("usable map", 16'(usablePortMap), 16'(pm[7:4]));
    chk("removable map", 16'(removablePortMap), 16'(pm[3:0]));
    chk("port count", 16'(numPorts), 16'(n));
    chk("removable bitmap", 16'(deviceRemovable), 16'(rem));
    chk("power mask", 16'(portPwrCtrlMask), 16'h00ff);
    chk("max power fs", 16'(maxPowerFs), 16'(ext ? img[9] : 8'h28));
    chk("max power hs", 16'(maxPowerHs), 16'(ext ? img[9] : 8'h57));
    chk("ctrl current fs", 16'(controllerCurrentFs), 16'(ext ? img[10] : 8'h50));
    chk("ctrl current hs", 16'(controllerCurrentHs), 16'(ext ? img[10] : 8'hae));
    chk("power good", 16'(portPowerGoodDelay), 16'(ext ? img[11] : 8'h32));
    chk("accept zero", 16'(acceptZeroDescriptorType), 16'(op[7]));
    chk("composite", 16'(partOfCompositeFlag), 16'(op[6]));
    chk("full speed", 16'(restrictToFullSpeed), 16'(op[5]));
    chk("no leds", 16'(suppressStatusLeds), 16'(op[4]));
    chk("ganged", 16'(sharedPortPowerSwitch), 16'(op[2]));
    chk("hub char", 16'(hubCharLo), 16'({~op[4], 3'b000, ~op[2], op[6], 1'b0, ~op[2]}));
    chk("done", 16'(configDone), 16'h0001);
    chk("select idle", 16'(spiCsN), 16'h0001);
  endtask : check_all

  // Random image with a chosen leading code
  task automatic fill(input logic [7:0] code);
    for (int i = 0; i < 13; i++) img[i] = 8'($random(seed));
    img[0] = code;
  endtask : fill

  // Reset for 20 cycles, let the loader read the image, then check
  task automatic load(input logic twoB);
    int k;
    for (int i = 0; i < 13; i++) ee_u.mem[i] = img[i];
    @(posedge mclk);
    rst_n <= 1'b0;
    addrTwoByte <= twoB;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    k = 0;
    while (configDone !== 1'b1 && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    @(negedge mclk);
    check_all;
    chk("opcode", 16'(lastOp), 16'h0003);
    chk("last address", 16'(lastAddr), img[0] == 8'hd0 || img[0] == 8'hd2 ? 16'h1 : 16'h0);
  endtask : load

  // -----------------------------------------------------------------
  // Main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    addrTwoByte = 1'b1;
    // blank part, then a near-miss leading code
    for (int i = 0; i < 13; i++) img[i] = 8'hff;
    load(1'b1);
    fill(8'hd1);
    load(1'b0);
    // corner port maps and option bytes
    for (int c = 0; c < 4; c++) begin
      fill(8'hd2);
      img[8] = pmTab[c];
      img[12] = opTab[c];
      load(c[0]);
    end
    // Random short and extended images in both address modes
    for (int r = 0; r < 10; r++) begin
      fill(r % 3 == 0 ? 8'hd0 : 8'hd2);
      load(r[1]);
    end
    // contents rewritten in service are ignored until reset
    for (int i = 0; i < 13; i++) ee_u.mem[i] = ~img[i];
    repeat (200) @(posedge mclk);
    check_all;
    fill(8'hd2);
    load(1'b1);
    final_report;
  end

  // Hang guard well beyond the expected run
  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    final_report;
  end
endmodule : testbench
